/* core/psc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the PSRAM controller
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSC_OFF_CMD 8'h00
`define PSC_OFF_ADDR 8'h04
`define PSC_OFF_WDATA 8'h08
`define PSC_OFF_CFGVAL 8'h0C
`define PSC_OFF_RDATA 8'h10
`define PSC_OFF_STATUS 8'h14
`define PSC_OFF_CFGMIR 8'h18
`define PSC_OFF_TCRFLR 8'h1C
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PSC_CR_PAGE 7
`define PSC_CR_TCR_LO 5
`define PSC_CR_SLEEP 4
`define PSC_CFG_RST 21'h00_0070
`define PSC_TOP_ADDR 21'h1F_FFFF
`define PSC_LANES_RST 2'h3
`define PSC_TCRFLR_RST 2'h3
`define PSC_RESP_OKAY 2'h0
`define PSC_RESP_SLVERR 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define PSC_CLK_MHZ 100
`define PSC_T_ACC_NS 70
`define PSC_ACC_CYC ((`PSC_T_ACC_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_T_CEM_NS 4000
`define PSC_CEM_CYC ((`PSC_T_CEM_NS * `PSC_CLK_MHZ) / 1000)
`define PSC_T_ZZ_US 10
`define PSC_ZZ_CYC (`PSC_T_ZZ_US * `PSC_CLK_MHZ + 1)
`define PSC_T_INIT_US 150
`define PSC_INIT_CYC (`PSC_T_INIT_US * `PSC_CLK_MHZ)
`define PSC_GAP_CYC 2
`endif

/* core/psc_pkg.sv */
// Types of the PSRAM controller
package psc_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_WRITE, OP_PIN_CFG, OP_SW_CFG_WR, OP_SW_CFG_RD, OP_SLEEP, OP_WAKE
  } psc_op_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ZZ_SETUP, ST_ACCESS, ST_GAP, ST_ZZ_HOLD, ST_SLEEP, ST_INIT
  } psc_state_e;
endpackage

/* core/psc_ctrl.sv */
// AXI4-Lite driven controller for an asynchronous page-mode PSRAM
//
// Function
// - Read: chip select, output enable, a byte select low, write enable high.
// - Controller never holds chip select or write enable low beyond max_select_low_time.
// - Controller picks a thermal_refresh_setting at or above case temperature.
// - Sleep bit one: sleep pin low over 10us enters partial refresh.
// - Sleep bit zero: pin low over 10us deep sleep; exit needs 150us.
// - Controller never uses the software sequence for deepest sleep.
// - Write right after sleep pin falls loads address bits into config_word.
// - Software sequence: two reads, then two writes or a write and read.
// - All four software accesses target the top address.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_ctrl #(
  parameter logic [15:0] INIT_CYC = 16'(`PSC_INIT_CYC)
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [20:0] mem_addr_out,
  output logic chip_select_n_out,
  output logic write_enable_n_out,
  output logic output_enable_n_out,
  output logic upper_byte_select_n_out,
  output logic lower_byte_select_n_out,
  output logic sleep_control_n_out,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe_out
);
  localparam int GAP_MAX = 3;
  localparam int ZZ_MIN = `PSC_ZZ_CYC;
  localparam int CEM_MAX = `PSC_CEM_CYC;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    return old;
  endfunction

  // Thermal setting ranked from coolest (0) to hottest (3)
  function automatic logic [1:0] tcr_rank(input logic [1:0] code);
    case (code)
      2'h3: return 2'h3;
      2'h0: return 2'h2;
      2'h1: return 2'h1;
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic op_is_write(input psc_pkg::psc_op_e op, input logic [1:0] step);
    case (op)
      psc_pkg::OP_WRITE, psc_pkg::OP_PIN_CFG: return 1'b1;
      psc_pkg::OP_SW_CFG_WR: return step[1];
      psc_pkg::OP_SW_CFG_RD: return step == 2'h2;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic bvalid_r, rvalid_r, refused_r, sw_used_r, deep_r;
  logic [1:0] bresp_r, rresp_r, lanes_r, tcr_floor_r, step_r;
  logic [31:0] rdata_r, wd_word, addr_word, cfg_word;
  logic [20:0] addr_r, cfgval_r, cfg_mirror_r;
  logic [15:0] wdata_r, mem_rdata_r, cnt_r;
  logic [15:0] dq_s1_r, dq_s2_r, dq_s3_r;
  psc_pkg::psc_state_e state_r;
  psc_pkg::psc_op_e op_r, cmd_op, launch_op;
  logic wr_fire, wr_hit, start, cmd_ok, launch, acc_wr, acc_done, acc_last, cfg_wr_op;
  logic [1:0] launch_step;

  assign wr_fire = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_r;
  assign s_axi_awready_out = wr_fire;
  assign s_axi_wready_out = wr_fire;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out = rresp_r;
  assign s_axi_rdata_out = rdata_r;
  assign wr_hit = s_axi_awaddr_in[7:5] == 3'h0 && s_axi_awaddr_in[1:0] == 2'h0;
  assign start = wr_fire && s_axi_awaddr_in == `PSC_OFF_CMD && s_axi_wstrb_in[0];
  assign cmd_op = psc_pkg::psc_op_e'(s_axi_wdata_in[2:0]);
  assign cfg_wr_op = cmd_op == psc_pkg::OP_PIN_CFG || cmd_op == psc_pkg::OP_SW_CFG_WR;
  assign wd_word = merge({16'h0000, wdata_r}, s_axi_wdata_in, s_axi_wstrb_in);
  assign addr_word = merge({11'h000, addr_r}, s_axi_wdata_in, s_axi_wstrb_in);
  assign cfg_word = merge({11'h000, cfgval_r}, s_axi_wdata_in, s_axi_wstrb_in);

  always_comb begin
    cmd_ok = 1'b0;
    case (state_r)
      psc_pkg::ST_IDLE: cmd_ok = cmd_op != psc_pkg::OP_NONE && cmd_op != psc_pkg::OP_WAKE;
      psc_pkg::ST_SLEEP: cmd_ok = cmd_op == psc_pkg::OP_WAKE;
      default: cmd_ok = 1'b0;
    endcase
    if (cfg_wr_op && tcr_rank(cfgval_r[`PSC_CR_TCR_LO +: 2]) < tcr_floor_r) begin
      cmd_ok = 1'b0;
    end
    if (cmd_op == psc_pkg::OP_SW_CFG_WR && !cfgval_r[`PSC_CR_SLEEP]) begin
      cmd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      bvalid_r <= 1'b0;
      bresp_r <= `PSC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_hit && s_axi_awaddr_in[4:2] != 3'h4 && s_axi_awaddr_in[4:2] != 3'h6) ?
                 `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      addr_r <= 21'h00_0000;
      wdata_r <= 16'h0000;
      lanes_r <= `PSC_LANES_RST;
      cfgval_r <= `PSC_CFG_RST;
      tcr_floor_r <= `PSC_TCRFLR_RST;
    end else if (wr_fire) begin
      case (s_axi_awaddr_in)
        `PSC_OFF_ADDR: addr_r <= addr_word[20:0];
        `PSC_OFF_WDATA: begin
          wdata_r <= wd_word[15:0];
          if (s_axi_wstrb_in[2]) begin
            lanes_r <= s_axi_wdata_in[17:16];
          end
        end
        `PSC_OFF_CFGVAL: cfgval_r <= cfg_word[20:0];
        `PSC_OFF_TCRFLR: tcr_floor_r <= s_axi_wstrb_in[0] ? s_axi_wdata_in[1:0] : tcr_floor_r;
        default: ;
      endcase
    end
  end

  // Refused command flag; a refusal in the clearing cycle wins
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      refused_r <= 1'b0;
    end else if (start && !cmd_ok) begin
      refused_r <= 1'b1;
    end else if (wr_fire && s_axi_awaddr_in == `PSC_OFF_STATUS) begin
      refused_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rvalid_r <= 1'b0;
      rresp_r <= `PSC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (s_axi_arvalid_in && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= `PSC_RESP_OKAY;
      case (s_axi_araddr_in)
        `PSC_OFF_CMD: rdata_r <= {29'h0000_0000, op_r};
        `PSC_OFF_ADDR: rdata_r <= {11'h000, addr_r};
        `PSC_OFF_WDATA: rdata_r <= {14'h0000, lanes_r, wdata_r};
        `PSC_OFF_CFGVAL: rdata_r <= {11'h000, cfgval_r};
        `PSC_OFF_RDATA: rdata_r <= {16'h0000, mem_rdata_r};
        `PSC_OFF_STATUS: rdata_r <= {27'h000_0000, sw_used_r, refused_r, deep_r,
                                     state_r == psc_pkg::ST_SLEEP, state_r != psc_pkg::ST_IDLE};
        `PSC_OFF_CFGMIR: rdata_r <= {11'h000, cfg_mirror_r};
        `PSC_OFF_TCRFLR: rdata_r <= {30'h0000_0000, tcr_floor_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `PSC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Data pin synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
      dq_s3_r <= 16'h0000;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  // ----------------------------------------
  // Memory sequencer
  // ----------------------------------------
  assign launch_op = state_r == psc_pkg::ST_IDLE ? cmd_op : op_r;
  assign launch_step = state_r == psc_pkg::ST_GAP ? 2'(step_r + 2'h1) : 2'h0;
  assign acc_wr = op_is_write(launch_op, launch_step);
  assign acc_last = op_r != psc_pkg::OP_SW_CFG_WR && op_r != psc_pkg::OP_SW_CFG_RD || step_r == 2'h3;
  assign acc_done = state_r == psc_pkg::ST_ACCESS && cnt_r == 16'h0000 &&
                    (!output_enable_n_out ? dq_s2_r == dq_s3_r : 1'b1);
  always_comb begin
    launch = 1'b0;
    case (state_r)
      psc_pkg::ST_IDLE: launch = start && cmd_ok && (cmd_op == psc_pkg::OP_READ || cmd_op == psc_pkg::OP_WRITE ||
                                  cmd_op == psc_pkg::OP_SW_CFG_WR || cmd_op == psc_pkg::OP_SW_CFG_RD);
      psc_pkg::ST_ZZ_SETUP: launch = 1'b1;
      psc_pkg::ST_GAP: launch = cnt_r == 16'h0000 && !acc_last;
      default: launch = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_r <= psc_pkg::ST_IDLE;
      op_r <= psc_pkg::OP_NONE;
      step_r <= 2'h0;
      cnt_r <= 16'h0000;
      mem_addr_out <= 21'h00_0000;
      chip_select_n_out <= 1'b1;
      write_enable_n_out <= 1'b1;
      output_enable_n_out <= 1'b1;
      upper_byte_select_n_out <= 1'b1;
      lower_byte_select_n_out <= 1'b1;
      sleep_control_n_out <= 1'b1;
      dq_out <= 16'h0000;
      dq_oe_out <= 2'h0;
    end else if (launch) begin
      op_r <= launch_op;
      step_r <= launch_step;
      state_r <= psc_pkg::ST_ACCESS;
      // Reads add the three synchroniser stages so the captured word was sampled after the access time
      cnt_r <= acc_wr ? 16'(`PSC_ACC_CYC - 1) : 16'(`PSC_ACC_CYC + 2);
      chip_select_n_out <= 1'b0;
      write_enable_n_out <= !acc_wr;
      output_enable_n_out <= acc_wr;
      if (launch_op == psc_pkg::OP_SW_CFG_WR || launch_op == psc_pkg::OP_SW_CFG_RD) begin
        mem_addr_out <= `PSC_TOP_ADDR;
        {upper_byte_select_n_out, lower_byte_select_n_out} <= 2'h0;
        dq_out <= launch_step == 2'h3 ? cfgval_r[15:0] : 16'h0000;
        dq_oe_out <= acc_wr ? 2'h3 : 2'h0;
      end else begin
        mem_addr_out <= launch_op == psc_pkg::OP_PIN_CFG ? cfgval_r : addr_r;
        {upper_byte_select_n_out, lower_byte_select_n_out} <= ~lanes_r;
        dq_out <= wdata_r;
        dq_oe_out <= acc_wr && launch_op != psc_pkg::OP_PIN_CFG ? lanes_r : 2'h0;
      end
    end else begin
      case (state_r)
        psc_pkg::ST_IDLE: if (start && cmd_ok) begin
          op_r <= cmd_op;
          sleep_control_n_out <= 1'b0;
          cnt_r <= 16'(`PSC_ZZ_CYC);
          state_r <= cmd_op == psc_pkg::OP_SLEEP ? psc_pkg::ST_ZZ_HOLD : psc_pkg::ST_ZZ_SETUP;
        end
        psc_pkg::ST_ACCESS: if (cnt_r != 16'h0000) begin
          cnt_r <= 16'(cnt_r - 16'h0001);
        end else if (acc_done) begin
          chip_select_n_out <= 1'b1;
          write_enable_n_out <= 1'b1;
          output_enable_n_out <= 1'b1;
          upper_byte_select_n_out <= 1'b1;
          lower_byte_select_n_out <= 1'b1;
          dq_oe_out <= 2'h0;
          cnt_r <= 16'(`PSC_GAP_CYC - 1);
          state_r <= psc_pkg::ST_GAP;
        end
        psc_pkg::ST_GAP: if (cnt_r != 16'h0000) begin
          cnt_r <= 16'(cnt_r - 16'h0001);
        end else begin
          sleep_control_n_out <= 1'b1;
          state_r <= psc_pkg::ST_IDLE;
        end
        psc_pkg::ST_ZZ_HOLD: if (cnt_r != 16'h0000) begin
          cnt_r <= 16'(cnt_r - 16'h0001);
        end else begin
          state_r <= psc_pkg::ST_SLEEP;
        end
        psc_pkg::ST_SLEEP: if (start && cmd_ok) begin
          sleep_control_n_out <= 1'b1;
          cnt_r <= INIT_CYC;
          state_r <= deep_r ? psc_pkg::ST_INIT : psc_pkg::ST_IDLE;
        end
        psc_pkg::ST_INIT: if (cnt_r != 16'h0000) begin
          cnt_r <= 16'(cnt_r - 16'h0001);
        end else begin
          state_r <= psc_pkg::ST_IDLE;
        end
        default: state_r <= psc_pkg::ST_IDLE;
      endcase
    end
  end

  // Read capture, config mirror and sleep kind
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mem_rdata_r <= 16'h0000;
      cfg_mirror_r <= `PSC_CFG_RST;
      sw_used_r <= 1'b0;
      deep_r <= 1'b0;
    end else begin
      if (acc_done && !output_enable_n_out) begin
        mem_rdata_r <= dq_s3_r;
        if (op_r == psc_pkg::OP_SW_CFG_RD && step_r == 2'h3) begin
          cfg_mirror_r <= {5'h00, dq_s3_r};
        end
      end
      if (acc_done && acc_last && op_r == psc_pkg::OP_PIN_CFG) begin
        cfg_mirror_r <= mem_addr_out;
      end
      if (acc_done && acc_last && op_r == psc_pkg::OP_SW_CFG_WR) begin
        cfg_mirror_r <= {5'h00, dq_out};
        sw_used_r <= 1'b1;
      end
      if (state_r == psc_pkg::ST_IDLE && start && cmd_ok && cmd_op == psc_pkg::OP_SLEEP) begin
        deep_r <= !cfg_mirror_r[`PSC_CR_SLEEP];
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [15:0] ce_low_cnt_r, zz_low_cnt_r;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ce_low_cnt_r <= 16'h0000;
      zz_low_cnt_r <= 16'h0000;
    end else begin
      ce_low_cnt_r <= chip_select_n_out ? 16'h0000 : 16'(ce_low_cnt_r + 16'h0001);
      zz_low_cnt_r <= sleep_control_n_out ? 16'h0000 : 16'(zz_low_cnt_r + 16'h0001);
    end
  end

  chk_ce_low_limit: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ce_low_cnt_r < 16'(CEM_MAX)) else $error("chip select low too long");
  chk_read_pins: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !chip_select_n_out && !output_enable_n_out |-> write_enable_n_out && dq_oe_out == 2'h0 &&
    !(upper_byte_select_n_out && lower_byte_select_n_out)) else $error("bad read pin levels");
  chk_sw_top_addr: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !chip_select_n_out && (op_r == psc_pkg::OP_SW_CFG_WR || op_r == psc_pkg::OP_SW_CFG_RD)
    |-> mem_addr_out == `PSC_TOP_ADDR) else $error("software access off top address");
  chk_sw_back2back: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $rose(chip_select_n_out) && !acc_last |-> ##[1:GAP_MAX] !chip_select_n_out)
    else $error("gap in software sequence");
  chk_sleep_entry: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    state_r == psc_pkg::ST_ZZ_HOLD ##1 state_r == psc_pkg::ST_SLEEP |-> zz_low_cnt_r > 16'(ZZ_MIN))
    else $error("sleep pin released too soon");
  chk_init_quiet: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $rose(sleep_control_n_out) && deep_r |-> chip_select_n_out [*8]) else $error("access during wake-up");
  chk_no_sw_deep: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !write_enable_n_out && op_r == psc_pkg::OP_SW_CFG_WR && step_r == 2'h3 |-> dq_out[`PSC_CR_SLEEP])
    else $error("software sequence would select deepest sleep");
  chk_pin_load: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $fell(sleep_control_n_out) && op_r == psc_pkg::OP_PIN_CFG |-> ##[1:2] !chip_select_n_out &&
    !write_enable_n_out) else $error("no write after sleep pin fall");
  chk_tcr_floor: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $fell(chip_select_n_out) && op_r == psc_pkg::OP_PIN_CFG
    |-> tcr_rank(mem_addr_out[`PSC_CR_TCR_LO +: 2]) >= tcr_floor_r) else $error("thermal setting too low");
  chk_sleep_idle: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    state_r == psc_pkg::ST_SLEEP || state_r == psc_pkg::ST_INIT |-> chip_select_n_out)
    else $error("access while asleep");
endmodule

/* sim/psc_mem_model.sv */
// Behavioural PSRAM at the controller's far side
`timescale 1ns/1ps
module psc_mem_model #(
  parameter real ACC_NS = 65.0,
  parameter real INIT_NS = 150000.0
) (
  input wire logic [20:0] addr_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic ub_n_in,
  input wire logic lb_n_in,
  input wire logic zz_n_in,
  input wire logic [15:0] dq_ctrl_in,
  input wire logic [1:0] dq_oe_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [int];
  logic [20:0] cr = 21'h00_0070;
  logic [20:0] wa;
  logic [15:0] wd, rw;
  logic [1:0] ln, le;
  bit sw_wr, pin_cfg, wr_act, rd_act;
  int sq;
  real t0, tz, t_init;
  initial dq_out = 16'h0000;
  function automatic bit off();
    return (!zz_n_in && !pin_cfg && $realtime - tz > 10000.0 && (!cr[4] || !sw_wr)) || $realtime < t_init;
  endfunction
  function automatic logic [15:0] peek(logic [20:0] a);
    return mem.exists(a) ? mem[a] : 16'h0000;
  endfunction
  task automatic step(bit w);
    if (off()) return;
    if (wa == 21'h1F_FFFF && (w ? sq >= 2 : sq < 2)) begin
      if (w && sq == 3) begin
        cr = {5'h00, wd};
        sw_wr = 1'b1;
      end
      sq = (w && sq == 3) ? 0 : sq + 1;
    end else begin
      sq = 0;
      rw = peek(wa);
      if (w) mem[wa] = {ln[1] ? wd[15:8] : rw[15:8], ln[0] ? wd[7:0] : rw[7:0]};
    end
  endtask
  // Any address or control change restarts the slow access time
  always @(addr_in, ce_n_in, oe_n_in, we_n_in, ub_n_in, lb_n_in) t0 = $realtime;
  always @(ce_n_in, we_n_in, oe_n_in) begin
    if (!ce_n_in && !we_n_in) begin
      if (!wr_act) ln = ~{ub_n_in, lb_n_in};
      wr_act = 1'b1;
    end else if (wr_act) begin
      wr_act = 1'b0;
      if (!zz_n_in) begin
        cr = wa;
        pin_cfg = 1'b1;
      end else step(1'b1);
    end else if (!ce_n_in && !oe_n_in) rd_act = 1'b1;
    else if (rd_act) begin
      rd_act = 1'b0;
      step(1'b0);
    end
  end
  // Unselected lanes toggle so stale data never looks valid
  always begin
    #1;
    if (!ce_n_in) wa = addr_in;
    if (wr_act) wd = dq_ctrl_in;
    le = ~{ub_n_in, lb_n_in};
    rw = (wa == 21'h1F_FFFF && sq == 3) ? cr[15:0] : peek(wa);
    for (int i = 0; i < 2; i++) begin
      if (dq_oe_in[i]) dq_out[i*8 +: 8] = dq_ctrl_in[i*8 +: 8];
      else if (rd_act && le[i] && !off() && $realtime - t0 >= ACC_NS) dq_out[i*8 +: 8] = rw[i*8 +: 8];
      else dq_out[i*8 +: 8] = ~dq_out[i*8 +: 8];
    end
  end
  always @(negedge zz_n_in) begin
    tz = $realtime;
    pin_cfg = 1'b0;
  end
  always @(posedge zz_n_in) begin
    if (!pin_cfg && $realtime - tz > 10000.0 && (!cr[4] || (!sw_wr && cr[2:0] == 3'h4))) begin
      foreach (mem[k]) mem[k] = ~mem[k];
      if (!cr[4]) t_init = $realtime + INIT_NS;
    end
  end
endmodule

/* sim/psc_ctrl_test.sv */
// Self-checking bench for the PSRAM controller
`timescale 1ns/1ps
module psc_ctrl_test;
  typedef struct {logic [20:0] a; logic [15:0] d; logic [1:0] l; logic [15:0] e;} psc_row_s;
  logic mclk_in, sys_rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, v;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, dq_oe_out;
  logic [20:0] mem_addr_out;
  logic chip_select_n_out, write_enable_n_out, output_enable_n_out, upper_byte_select_n_out, lower_byte_select_n_out;
  logic sleep_control_n_out;
  logic [15:0] dq_in, dq_out;
  int fail_count = 0;
  int checked = 0;
  psc_row_s rows [6] = '{'{21'h00_0010, 16'h1234, 2'h3, 16'h1234}, '{21'h00_0010, 16'hABCD, 2'h1, 16'h12CD},
    '{21'h00_0010, 16'hEF00, 2'h2, 16'hEFCD}, '{21'h1F_FFFE, 16'h5A5A, 2'h3, 16'h5A5A},
    '{21'h1F_FFFF, 16'h7777, 2'h3, 16'h7777}, '{21'h00_0020, 16'h9999, 2'h0, 16'h0000}};
  psc_ctrl #(.INIT_CYC(16'h0032)) dut_u (.mclk_in, .sys_rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .mem_addr_out, .chip_select_n_out, .write_enable_n_out,
    .output_enable_n_out, .upper_byte_select_n_out, .lower_byte_select_n_out, .sleep_control_n_out, .dq_in, .dq_out,
    .dq_oe_out);
  psc_mem_model #(.INIT_NS(500.0)) mdl_u (.addr_in(mem_addr_out), .ce_n_in(chip_select_n_out),
    .we_n_in(write_enable_n_out), .oe_n_in(output_enable_n_out), .ub_n_in(upper_byte_select_n_out),
    .lb_n_in(lower_byte_select_n_out), .zz_n_in(sleep_control_n_out), .dq_ctrl_in(dq_out), .dq_oe_in(dq_oe_out),
    .dq_out(dq_in));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge mclk_in);
    n++;
    if (n > 4000) begin
      $display("Error at %0t: no answer", $time);
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    do tick(n); while (s_axi_awready_out !== 1'b1);
    s_axi_awvalid_in <= 1'b0;
    s_axi_wvalid_in <= 1'b0;
    s_axi_bready_in <= 1'b1;
    do tick(n); while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    chk({30'h0, s_axi_bresp_out}, {30'h0, er});
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    int n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do tick(n); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    s_axi_rready_in <= 1'b1;
    do tick(n); while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    d = s_axi_rdata_out;
    chk({30'h0, s_axi_rresp_out}, {30'h0, er});
  endtask
  task automatic wait_st(input logic [31:0] m, input logic [31:0] e);
    int n = 0;
    do begin
      axr(8'h14, v);
      tick(n);
    end while ((v & m) !== e);
  endtask
  task automatic cmd(input logic [2:0] op);
    axw(8'h00, {29'h0, op});
    wait_st(32'h1, 32'h0);
  endtask
  task automatic mem_rd(input logic [20:0] a, output logic [31:0] d);
    axw(8'h04, {11'h0, a});
    axw(8'h08, 32'h0003_0000);
    cmd(3'h1);
    axr(8'h10, d);
  endtask
  initial begin
    sys_rst_in = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 5'h00;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
    s_axi_wstrb_in = 4'hF;
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    axr(8'h0C, v);
    chk(v, 32'h0000_0070);
    axr(8'h1C, v);
    chk(v, 32'h0000_0003);
    chk({31'h0, sleep_control_n_out}, 32'h1);
    foreach (rows[i]) begin
      axw(8'h04, {11'h0, rows[i].a});
      axw(8'h08, {14'h0, rows[i].l, rows[i].d});
      cmd(3'h2);
      mem_rd(rows[i].a, v);
      chk(v, {16'h0, rows[i].e});
    end
    axr(8'h20, v, 2'h2);
    axw(8'h10, 32'h0, 2'h2);
    axw(8'h00, 32'h0);
    axr(8'h14, v);
    chk(v & 32'h8, 32'h8);
    axw(8'h14, 32'h0);
    cmd(3'h5);
    axr(8'h18, v);
    chk(v, 32'h0000_0070);
    chk({31'h0, mdl_u.sw_wr}, 32'h0);
    axw(8'h0C, 32'h0000_0060);
    cmd(3'h4);
    axr(8'h14, v);
    chk(v & 32'h8, 32'h8);
    axw(8'h14, 32'h0);
    axw(8'h0C, 32'h0000_0010);
    cmd(3'h3);
    chk({11'h0, mdl_u.cr}, 32'h0000_0070);
    axw(8'h0C, 32'h0000_00F0);
    cmd(3'h4);
    axr(8'h18, v);
    chk(v, 32'h0000_00F0);
    chk({11'h0, mdl_u.cr}, 32'h0000_00F0);
    axr(8'h14, v);
    chk(v & 32'h10, 32'h10);
    mem_rd(21'h1F_FFFF, v);
    chk(v, 32'h0000_7777);
    axw(8'h0C, 32'h0000_0060);
    cmd(3'h3);
    chk({11'h0, mdl_u.cr}, 32'h0000_0060);
    axw(8'h00, 32'h6);
    wait_st(32'h6, 32'h6);
    chk({31'h0, sleep_control_n_out}, 32'h0);
    axw(8'h00, 32'h7);
    wait_st(32'h1, 32'h0);
    mem_rd(21'h00_0010, v);
    chk(v, 32'h0000_1032);
    wrap_up();
  end
endmodule
